/* File: include/mpc_pkg.sv */
// Purpose: Constants shared by the metering path control block
// Assumes: 32-bit register port, word offsets as printed
// Notes: Field positions of the path control register
`default_nettype none
package mpc_pkg;
    localparam logic [11:0] PATH_CTRL_ADDR = 12'h184;
    localparam logic [11:0] ACC_POWER_ADDR = 12'h189;
    localparam logic [11:0] STATUS_ADDR = 12'h18a;
    localparam logic [31:0] PATH_CTRL_RESET = 32'h0040_0000;
    localparam logic [31:0] PATH_CTRL_MASK = 32'h007f_ffff;
    localparam int VERIFY_BIT = 22;
    localparam int DETECT_BIT = 21;
    localparam int HPF_BYPASS_BIT = 20;
    localparam int PHC_EN_BIT = 19;
    localparam int PHC_DIR_BIT = 18;
    localparam int I_EN_BIT = 17;
    localparam int U_EN_BIT = 16;
    localparam int PHC_MAG_LSB = 8;
    localparam int I_GAIN_LSB = 4;
    localparam int U_GAIN_LSB = 0;
    localparam int PHC_MAG_W = 8;
    localparam int GAIN_W = 4;
    typedef enum logic [1:0] {MODE_VERIFY, MODE_DETECT, MODE_FULL} run_mode_t;
endpackage
`default_nettype wire

/* File: logic/sample_fifo.sv */
// Purpose: Small synchronous FIFO for sample pairs
// Assumes: One clock, synchronous active-low reset
// Notes: Read data come from a register
`default_nettype none
module sample_fifo #(
    parameter int WIDTH = 48,
    parameter int DEPTH = 4
) (
    // Clock and reset
    input wire logic sys_clk_i,
    input wire logic rstn_i,
    // Fill side
    input wire logic in_valid_i,
    output logic in_ready_o,
    input wire logic [WIDTH-1:0] in_data_i,
    // Drain side
    output logic out_valid_o,
    input wire logic out_ready_i,
    output logic [WIDTH-1:0] out_data_o
);
    localparam int AW = $clog2(DEPTH);
    initial begin
        if (DEPTH < 2 || (1 << AW) != DEPTH) $error("DEPTH must be a power of two");
    end
    logic [WIDTH-1:0] mem_ff [DEPTH];
    logic [AW:0] wr_ptr_ff;
    logic [AW:0] rd_ptr_ff;
    logic out_valid_ff;
    logic [WIDTH-1:0] out_data_ff;
    logic empty;
    logic full;
    logic load;
    assign empty = wr_ptr_ff == rd_ptr_ff;
    assign full = (wr_ptr_ff[AW] != rd_ptr_ff[AW]) && (wr_ptr_ff[AW-1:0] == rd_ptr_ff[AW-1:0]);
    assign in_ready_o = !full;
    assign load = !empty && (!out_valid_ff || out_ready_i);
    assign out_valid_o = out_valid_ff;
    assign out_data_o = out_data_ff;
    always_ff @(posedge sys_clk_i) begin
        if (in_valid_i && !full) begin
            mem_ff[wr_ptr_ff[AW-1:0]] <= in_data_i;
        end
    end
    always_ff @(posedge sys_clk_i) begin
        if (!rstn_i) begin
            wr_ptr_ff <= '0;
        end else if (in_valid_i && !full) begin
            wr_ptr_ff <= wr_ptr_ff + 1'b1;
        end
    end
    always_ff @(posedge sys_clk_i) begin
        if (!rstn_i) begin
            rd_ptr_ff <= '0;
        end else if (load) begin
            rd_ptr_ff <= rd_ptr_ff + 1'b1;
        end
    end
    always_ff @(posedge sys_clk_i) begin
        if (!rstn_i) begin
            out_valid_ff <= 1'b0;
            out_data_ff <= '0;
        end else if (load) begin
            out_valid_ff <= 1'b1;
            out_data_ff <= mem_ff[rd_ptr_ff[AW-1:0]];
        end else if (out_ready_i) begin
            out_valid_ff <= 1'b0;
        end
    end
endmodule
`default_nettype wire

/* File: logic/metering_path_control.sv */
// Purpose: Path control register and front-end sample conditioning of a metering channel pair
// Assumes: Samples arrive as valid/ready stream; register port answers reads one cycle later
// Notes: Conditioned samples pass through a small FIFO before leaving
`default_nettype none
module metering_path_control #(
    parameter int SAMPLE_W = 24,
    parameter int FIFO_DEPTH = 4,
    parameter int HPF_SHIFT = 8
) (
    // Clock and reset
    input wire logic sys_clk_i,
    input wire logic rstn_i,
    // Extra reset sources: line reset and global software reset
    input wire logic line_reset_i,
    input wire logic soft_reset_i,
    // Register port
    input wire logic [11:0] reg_addr_i,
    input wire logic [31:0] reg_wdata_i,
    input wire logic reg_wr_i,
    input wire logic reg_rd_i,
    output logic [31:0] reg_rdata_o,
    // Mode events
    input wire logic detect_mode_enter_i,
    input wire logic [31:0] avg_power_i,
    input wire logic avg_power_valid_i,
    // Sample input
    input wire logic in_valid_i,
    output logic in_ready_o,
    input wire logic signed [SAMPLE_W-1:0] cur_sample_i,
    input wire logic signed [SAMPLE_W-1:0] volt_sample_i,
    // Sample output
    output logic out_valid_o,
    input wire logic out_ready_i,
    output logic signed [SAMPLE_W-1:0] cur_out_o,
    output logic signed [SAMPLE_W-1:0] volt_out_o,
    // Mode and accumulation outputs
    output logic [1:0] run_mode_o,
    output logic [31:0] acc_power_o
);
    localparam int DLY_N = 1 << mpc_pkg::PHC_MAG_W;
    initial begin
        if (SAMPLE_W < 8 || HPF_SHIFT < 1 || HPF_SHIFT > 16) $error("unsupported parameters");
    end

    logic rst_all;
    logic [31:0] ctrl_ff;
    logic [31:0] acc_ff;
    logic [31:0] rdata_ff;
    mpc_pkg::run_mode_t mode;
    logic verify_only_select;
    logic detection_only_select;
    logic highpass_bypass;
    logic phase_comp_enable;
    logic phase_comp_direction;
    logic current_input_enable;
    logic voltage_input_enable;
    logic [7:0] phase_comp_magnitude;
    logic [3:0] current_gain_code;
    logic [3:0] voltage_gain_code;
    logic step;
    logic push;
    logic stage_vld_ff;
    logic fifo_ready;

    assign rst_all = !rstn_i || line_reset_i || soft_reset_i;

    assign verify_only_select = ctrl_ff[mpc_pkg::VERIFY_BIT];
    assign detection_only_select = ctrl_ff[mpc_pkg::DETECT_BIT];
    assign highpass_bypass = ctrl_ff[mpc_pkg::HPF_BYPASS_BIT];
    assign phase_comp_enable = ctrl_ff[mpc_pkg::PHC_EN_BIT];
    assign phase_comp_direction = ctrl_ff[mpc_pkg::PHC_DIR_BIT];
    assign current_input_enable = ctrl_ff[mpc_pkg::I_EN_BIT];
    assign voltage_input_enable = ctrl_ff[mpc_pkg::U_EN_BIT];
    assign phase_comp_magnitude = ctrl_ff[mpc_pkg::PHC_MAG_LSB +: mpc_pkg::PHC_MAG_W];
    assign current_gain_code = ctrl_ff[mpc_pkg::I_GAIN_LSB +: mpc_pkg::GAIN_W];
    assign voltage_gain_code = ctrl_ff[mpc_pkg::U_GAIN_LSB +: mpc_pkg::GAIN_W];

    // Control register; a hardware detection-mode entry wins over a write
    always_ff @(posedge sys_clk_i) begin
        if (rst_all) begin
            ctrl_ff <= mpc_pkg::PATH_CTRL_RESET;
        end else begin
            if (reg_wr_i && reg_addr_i == mpc_pkg::PATH_CTRL_ADDR) begin
                ctrl_ff <= reg_wdata_i & mpc_pkg::PATH_CTRL_MASK;
            end
            if (detect_mode_enter_i) begin
                ctrl_ff[mpc_pkg::DETECT_BIT] <= 1'b1;
                ctrl_ff[mpc_pkg::VERIFY_BIT] <= 1'b0;
            end
        end
    end

    always_comb begin
        if (verify_only_select) begin
            mode = mpc_pkg::MODE_VERIFY;
        end else if (detection_only_select) begin
            mode = mpc_pkg::MODE_DETECT;
        end else begin
            mode = mpc_pkg::MODE_FULL;
        end
    end
    assign run_mode_o = mode;

    // Accumulation power: software preset, or hardware copy in full mode
    always_ff @(posedge sys_clk_i) begin
        if (rst_all) begin
            acc_ff <= '0;
        end else if (mode == mpc_pkg::MODE_FULL && avg_power_valid_i) begin
            acc_ff <= avg_power_i;
        end else if (reg_wr_i && reg_addr_i == mpc_pkg::ACC_POWER_ADDR) begin
            acc_ff <= reg_wdata_i;
        end
    end
    assign acc_power_o = acc_ff;

    always_ff @(posedge sys_clk_i) begin
        if (rst_all) begin
            rdata_ff <= '0;
        end else if (reg_rd_i) begin
            unique case (reg_addr_i)
                mpc_pkg::PATH_CTRL_ADDR: rdata_ff <= ctrl_ff;
                mpc_pkg::ACC_POWER_ADDR: rdata_ff <= acc_ff;
                mpc_pkg::STATUS_ADDR: rdata_ff <= {30'h0, mode};
                default: rdata_ff <= '0;
            endcase
        end else begin
            rdata_ff <= '0;
        end
    end
    assign reg_rdata_o = rdata_ff;

    // Stage register takes a sample when empty or draining; it moves on to the FIFO at the first later cycle in which the FIFO has room
    assign in_ready_o = !stage_vld_ff || fifo_ready;
    assign step = in_valid_i && in_ready_o;
    assign push = stage_vld_ff && fifo_ready;
    always_ff @(posedge sys_clk_i) begin
        if (rst_all) begin
            stage_vld_ff <= 1'b0;
        end else if (step) begin
            stage_vld_ff <= 1'b1;
        end else if (push) begin
            stage_vld_ff <= 1'b0;
        end
    end

    function automatic logic signed [SAMPLE_W-1:0] apply_gain(input logic signed [SAMPLE_W-1:0] s,
                                                              input logic [3:0] code);
        logic [2:0] sh;
        sh = code[2:0];
        if (sh > 3'h5) begin
            apply_gain = s;
        end else if (code[3]) begin
            apply_gain = s <<< sh;
        end else begin
            apply_gain = s >>> sh;
        end
    endfunction

    // Stage 1: gate and gain, taken with the current control value
    logic signed [SAMPLE_W-1:0] stage_ff [2];
    logic signed [SAMPLE_W-1:0] hpf_out [2];
    logic signed [SAMPLE_W-1:0] dly_out [2];
    logic signed [SAMPLE_W-1:0] gated [2];
    logic [1:0] ch_enable;
    logic [3:0] ch_gain [2];
    logic [1:0] ch_delay;
    assign ch_enable = {voltage_input_enable, current_input_enable};
    assign ch_gain[0] = current_gain_code;
    assign ch_gain[1] = voltage_gain_code;
    assign gated[0] = ch_enable[0] ? cur_sample_i : '0;
    assign gated[1] = ch_enable[1] ? volt_sample_i : '0;
    // Direction one delays voltage (index 1), zero delays current
    assign ch_delay = phase_comp_enable ? (phase_comp_direction ? 2'b10 : 2'b01) : 2'b00;

    genvar g;
    generate
        for (g = 0; g < 2; g++) begin : gen_ch
            logic signed [SAMPLE_W+15:0] dc_ff;
            logic signed [SAMPLE_W-1:0] dc_est;
            logic signed [SAMPLE_W-1:0] hist_ff [DLY_N];
            logic [7:0] wr_ff;
            always_ff @(posedge sys_clk_i) begin
                if (rst_all) begin
                    stage_ff[g] <= '0;
                end else if (step) begin
                    stage_ff[g] <= apply_gain(gated[g], ch_gain[g]);
                end
            end
            // DC estimate by leaky integrator
            assign dc_est = SAMPLE_W'(dc_ff >>> HPF_SHIFT);
            always_ff @(posedge sys_clk_i) begin
                if (rst_all) begin
                    dc_ff <= '0;
                end else if (push) begin
                    dc_ff <= dc_ff + (SAMPLE_W + 16)'(stage_ff[g]) - (SAMPLE_W + 16)'(dc_est);
                end
            end
            assign hpf_out[g] = highpass_bypass ? stage_ff[g] : stage_ff[g] - dc_est;
            // Delay line: one step per magnitude count
            always_ff @(posedge sys_clk_i) begin
                if (rst_all) begin
                    wr_ff <= '0;
                end else if (push) begin
                    wr_ff <= wr_ff + 8'h01;
                end
            end
            always_ff @(posedge sys_clk_i) begin
                if (push) begin
                    hist_ff[wr_ff] <= hpf_out[g];
                end
            end
            assign dly_out[g] = (ch_delay[g] && phase_comp_magnitude != 8'h00)
                ? hist_ff[8'(wr_ff - phase_comp_magnitude)] : hpf_out[g];
        end
    endgenerate

    sample_fifo #(
        .WIDTH(2 * SAMPLE_W),
        .DEPTH(FIFO_DEPTH)
    ) u_fifo (
        .sys_clk_i(sys_clk_i),
        .rstn_i(!rst_all),
        .in_valid_i(push),
        .in_ready_o(fifo_ready),
        .in_data_i({dly_out[1], dly_out[0]}),
        .out_valid_o(out_valid_o),
        .out_ready_i(out_ready_i),
        .out_data_o({volt_out_o, cur_out_o})
    );
endmodule
`default_nettype wire

/* File: tb/metering_path_control_properties.sv */
// Purpose: Port-level properties of the metering path control block
// Assumes: Synchronous resets; read data stand one cycle after the strobe
// Notes: Bound to the block after the module
`default_nettype none
module metering_path_control_properties #(
    parameter int SAMPLE_W = 24
) (
    // Clock and resets
    input wire logic sys_clk_i,
    input wire logic rstn_i,
    input wire logic line_reset_i,
    input wire logic soft_reset_i,
    // Register port and mode events
    input wire logic [11:0] reg_addr_i,
    input wire logic [31:0] reg_wdata_i,
    input wire logic reg_wr_i,
    input wire logic reg_rd_i,
    input wire logic [31:0] reg_rdata_o,
    input wire logic detect_mode_enter_i,
    input wire logic [31:0] avg_power_i,
    input wire logic avg_power_valid_i,
    // Outputs
    input wire logic out_valid_o,
    input wire logic out_ready_i,
    input wire logic signed [SAMPLE_W-1:0] cur_out_o,
    input wire logic [1:0] run_mode_o,
    input wire logic [31:0] acc_power_o
);
    logic rst_any;
    logic mapped;
    assign rst_any = !rstn_i || line_reset_i || soft_reset_i;
    assign mapped = reg_addr_i inside {mpc_pkg::PATH_CTRL_ADDR, mpc_pkg::ACC_POWER_ADDR, mpc_pkg::STATUS_ADDR};
    a_reset_state: assert property (@(posedge sys_clk_i) !rstn_i |=>
        run_mode_o == 2'h0 && acc_power_o == 32'h0 && !out_valid_o) else $error("state not default after reset");
    a_rdata_idle: assert property (@(posedge sys_clk_i) disable iff (rst_any)
        !reg_rd_i |=> reg_rdata_o == 32'h0) else $error("read data without read");
    a_unmapped_read: assert property (@(posedge sys_clk_i) disable iff (rst_any)
        reg_rd_i && !mapped |=> reg_rdata_o == 32'h0) else $error("unmapped read not zero");
    a_ctrl_upper: assert property (@(posedge sys_clk_i) disable iff (rst_any)
        reg_rd_i && reg_addr_i == mpc_pkg::PATH_CTRL_ADDR |=> reg_rdata_o[31:23] == 9'h0) else $error("upper bits set");
    a_detect_enter: assert property (@(posedge sys_clk_i) disable iff (rst_any)
        detect_mode_enter_i |=> run_mode_o == 2'h1) else $error("detect mode not entered");
    a_full_copy: assert property (@(posedge sys_clk_i) disable iff (rst_any)
        avg_power_valid_i && run_mode_o == 2'h2 |=> acc_power_o == $past(avg_power_i)) else $error("power not copied");
    a_detect_hold: assert property (@(posedge sys_clk_i) disable iff (rst_any)
        run_mode_o == 2'h1 && !reg_wr_i |=> $stable(acc_power_o)) else $error("preset power changed");
    a_out_stands: assert property (@(posedge sys_clk_i) disable iff (rst_any)
        out_valid_o && !out_ready_i |=> out_valid_o && $stable(cur_out_o)) else $error("output dropped");
endmodule
bind metering_path_control metering_path_control_properties #(.SAMPLE_W(SAMPLE_W)) u_props (
    .sys_clk_i(sys_clk_i), .rstn_i(rstn_i), .line_reset_i(line_reset_i), .soft_reset_i(soft_reset_i),
    .reg_addr_i(reg_addr_i), .reg_wdata_i(reg_wdata_i), .reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i),
    .reg_rdata_o(reg_rdata_o), .detect_mode_enter_i(detect_mode_enter_i), .avg_power_i(avg_power_i),
    .avg_power_valid_i(avg_power_valid_i), .out_valid_o(out_valid_o), .out_ready_i(out_ready_i),
    .cur_out_o(cur_out_o), .run_mode_o(run_mode_o), .acc_power_o(acc_power_o));
`default_nettype wire

/* File: tb/metering_path_control_test.sv */
// Purpose: Self-checking bench of the metering path control block
// Assumes: Reset held 12 cycles; output side ready unless a task stalls it
// Notes: Short filter shift keeps the DC settling test brief
`default_nettype none
module metering_path_control_test;
    timeunit 1ns;
    timeprecision 1ps;
    logic sys_clk = 1'b0, rstn = 1'b0, lrst = 1'b0, srst = 1'b0, wr = 1'b0, rd = 1'b0;
    logic dme = 1'b0, apv = 1'b0, iv = 1'b0, ordy = 1'b1, ir, ov;
    logic [11:0] addr = 12'h0;
    logic [31:0] wd = 32'h0, ap = 32'h0, rdata, accp, r;
    logic signed [23:0] ci = 24'sh0, vi = 24'sh0, co, vo;
    logic [1:0] mode;
    int n_errors = 0;
    int tests_run = 0;
    metering_path_control #(.HPF_SHIFT(2)) dut (.sys_clk_i(sys_clk), .rstn_i(rstn), .line_reset_i(lrst),
        .soft_reset_i(srst), .reg_addr_i(addr), .reg_wdata_i(wd), .reg_wr_i(wr), .reg_rd_i(rd),
        .reg_rdata_o(rdata), .detect_mode_enter_i(dme), .avg_power_i(ap), .avg_power_valid_i(apv),
        .in_valid_i(iv), .in_ready_o(ir), .cur_sample_i(ci), .volt_sample_i(vi), .out_valid_o(ov),
        .out_ready_i(ordy), .cur_out_o(co), .volt_out_o(vo), .run_mode_o(mode), .acc_power_o(accp));
    initial begin
        forever #5 sys_clk = ~sys_clk;
    end
    task summarize;
        $display("comparisons %0d mismatches %0d", tests_run, n_errors);
        if (n_errors == 0 && tests_run > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask
    task chk(input logic [31:0] got, input logic [31:0] exp);
        tests_run++;
        if (got !== exp) begin
            n_errors++;
            $display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task wreg(input logic [11:0] a, input logic [31:0] d);
        @(posedge sys_clk) addr <= a; wd <= d; wr <= 1'b1;
        @(posedge sys_clk) wr <= 1'b0;
    endtask
    task rreg(input logic [11:0] a);
        @(posedge sys_clk) addr <= a; rd <= 1'b1;
        @(posedge sys_clk) rd <= 1'b0;
        #1 r = rdata;
    endtask
    task pulse_ap(input logic [31:0] v);
        @(posedge sys_clk) ap <= v; apv <= 1'b1;
        @(posedge sys_clk) apv <= 1'b0;
        #1;
    endtask
    task send(input logic signed [23:0] c, input logic signed [23:0] v);
        int k;
        @(posedge sys_clk) ci <= c; vi <= v; iv <= 1'b1;
        @(posedge sys_clk) iv <= 1'b0;
        for (k = 0; k < 20; k++) begin
            #1;
            if (ov === 1'b1) break;
            @(posedge sys_clk);
        end
        if (k == 20) begin
            n_errors++;
            summarize;
        end
    endtask
    function automatic logic signed [23:0] gn(input logic signed [23:0] s, input logic [3:0] c);
        if (c <= 4'h5) return s >>> c;
        if (c >= 4'h8 && c <= 4'hd) return s <<< (c - 4'h8);
        return s;
    endfunction
    task t_reset;
        rreg(mpc_pkg::PATH_CTRL_ADDR); chk(r, 32'h0040_0000);
        chk({30'h0, mode}, 32'h0);
        wreg(mpc_pkg::PATH_CTRL_ADDR, 32'hffff_ffff);
        rreg(mpc_pkg::PATH_CTRL_ADDR); chk(r, 32'h007f_ffff);
        rreg(12'h0ff); chk(r, 32'h0);
        @(posedge sys_clk) lrst <= 1'b1;
        @(posedge sys_clk) lrst <= 1'b0;
        rreg(mpc_pkg::PATH_CTRL_ADDR); chk(r, 32'h0040_0000);
        wreg(mpc_pkg::PATH_CTRL_ADDR, 32'h0000_0000);
        @(posedge sys_clk) srst <= 1'b1;
        @(posedge sys_clk) srst <= 1'b0;
        rreg(mpc_pkg::PATH_CTRL_ADDR); chk(r, 32'h0040_0000);
    endtask
    task t_modes;
        @(posedge sys_clk) dme <= 1'b1;
        @(posedge sys_clk) dme <= 1'b0;
        rreg(mpc_pkg::PATH_CTRL_ADDR); chk(r, 32'h0020_0000);
        chk({30'h0, mode}, 32'h1);
        wreg(mpc_pkg::ACC_POWER_ADDR, 32'h1234_5678);
        pulse_ap(32'hcafe_0001); chk(accp, 32'h1234_5678);
        wreg(mpc_pkg::PATH_CTRL_ADDR, 32'h0000_0000);
        #1 chk({30'h0, mode}, 32'h2);
        pulse_ap(32'hcafe_0001); chk(accp, 32'hcafe_0001);
        rreg(mpc_pkg::ACC_POWER_ADDR); chk(r, 32'hcafe_0001);
    endtask
    task t_gain;
        for (int c = 0; c < 16; c++) begin
            wreg(mpc_pkg::PATH_CTRL_ADDR, 32'h0013_0000 | (c << 4) | (15 - c));
            send(24'sh000400, -24'sh000400);
            chk(32'(co), 32'(gn(24'sh000400, 4'(c))));
            chk(32'(vo), 32'(gn(-24'sh000400, 4'(15 - c))));
        end
    endtask
    task t_enables;
        wreg(mpc_pkg::PATH_CTRL_ADDR, 32'h0011_0000);
        send(24'sh000123, 24'sh000456); chk(32'(co), 32'h0);
        chk(32'(vo), 32'h0000_0456);
        wreg(mpc_pkg::PATH_CTRL_ADDR, 32'h0012_0000);
        send(24'sh000123, 24'sh000456); chk(32'(vo), 32'h0);
        chk(32'(co), 32'h0000_0123);
        wreg(mpc_pkg::PATH_CTRL_ADDR, 32'h0003_0000);
        for (int k = 0; k < 30; k++) send(24'sh001000, 24'sh001000);
        chk(32'(co < 24'sh000800), 32'h1);
    endtask
    task t_phase;
        wreg(mpc_pkg::PATH_CTRL_ADDR, 32'h001f_0100);
        send(24'sh000011, 24'sh000021);
        send(24'sh000012, 24'sh000022); chk(32'(co), 32'h0000_0012);
        chk(32'(vo), 32'h0000_0021);
        wreg(mpc_pkg::PATH_CTRL_ADDR, 32'h001b_0100);
        send(24'sh000013, 24'sh000023); chk(32'(co), 32'h0000_0012);
        chk(32'(vo), 32'h0000_0023);
    endtask
    task t_fifo;
        int acc, got;
        acc = 0;
        got = 0;
        wreg(mpc_pkg::PATH_CTRL_ADDR, 32'h0013_0000);
        @(posedge sys_clk) ordy <= 1'b0; iv <= 1'b1;
        for (int k = 0; k < 10; k++) begin
            #1 if (ir === 1'b1) acc++;
            @(posedge sys_clk);
        end
        iv <= 1'b0;
        chk(32'(acc >= 4 && acc < 10), 32'h1);
        @(posedge sys_clk) ordy <= 1'b1;
        for (int k = 0; k < 20; k++) begin
            #1 if (ov === 1'b1) got++;
            @(posedge sys_clk);
        end
        chk(32'(got), 32'(acc));
    endtask
    initial begin
        repeat (12) @(posedge sys_clk);
        rstn <= 1'b1;
        t_reset;
        t_modes;
        t_gain;
        t_enables;
        t_phase;
        t_fifo;
        summarize;
    end
endmodule
`default_nettype wire
